// >>> design/adc_scan_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module adc_scan_sequencer #(
   parameter logic [15:0] LIST_MASK = adc_scan_pkg::LIST_MASK_FULL
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic regWrite,
   input wire logic [3:0] regAddr,
   input wire logic [23:0] regWdata,
   input wire logic [1:0] conversion_repeat_select,
   input wire logic auto_zero_chop_enable,
   input wire logic [1:0] outputFormat,
   input wire logic pwrWrite,
   input wire logic [1:0] pwrWdata,
   input wire logic convDone,
   input wire logic [23:0] convData,
   output logic convStart,
   output logic [7:0] muxCode,
   output logic [1:0] forcedGain,
   output logic [1:0] powerState,
   output logic scanActive,
   output logic [23:0] result_word,
   output logic dataReady,
   output logic [7:0] input_selection,
   output logic [23:0] channel_list_config,
   output logic [23:0] gapCount
);
   typedef enum logic [1:0] {IDLE, CONV, WAIT_CONV, GAP} state_t;

   function automatic logic [7:0] chanCode(input logic [3:0] idx);
      logic [7:0] c;
      c = 8'h08;
      // internal input codes
      unique case (idx)
         4'hf: c = 8'h88;
         4'he: c = 8'hf8;
         4'hd: c = 8'h98;
         4'hc: c = 8'hde;
         4'hb: c = 8'h67;
         4'ha: c = 8'h45;
         4'h9: c = 8'h23;
         4'h8: c = 8'h01;
         4'h7: c = 8'h78;
         4'h6: c = 8'h68;
         4'h5: c = 8'h58;
         4'h4: c = 8'h48;
         4'h3: c = 8'h38;
         4'h2: c = 8'h28;
         4'h1: c = 8'h18;
         4'h0: c = 8'h08;
      endcase
      return c;
   endfunction

   function automatic logic [1:0] chanGain(input logic [3:0] idx);
      logic [1:0] g;
      g = adc_scan_pkg::GAIN_NONE;
      // only common-mode, supply and temperature force a gain
      unique case (idx)
         4'hf: g = adc_scan_pkg::GAIN_NONE;
         4'he: g = adc_scan_pkg::GAIN_ONE;
         4'hd: g = adc_scan_pkg::GAIN_THIRD;
         4'hc: g = adc_scan_pkg::GAIN_ONE;
         4'hb: g = adc_scan_pkg::GAIN_NONE;
         4'ha: g = adc_scan_pkg::GAIN_NONE;
         4'h9: g = adc_scan_pkg::GAIN_NONE;
         4'h8: g = adc_scan_pkg::GAIN_NONE;
         4'h7: g = adc_scan_pkg::GAIN_NONE;
         4'h6: g = adc_scan_pkg::GAIN_NONE;
         4'h5: g = adc_scan_pkg::GAIN_NONE;
         4'h4: g = adc_scan_pkg::GAIN_NONE;
         4'h3: g = adc_scan_pkg::GAIN_NONE;
         4'h2: g = adc_scan_pkg::GAIN_NONE;
         4'h1: g = adc_scan_pkg::GAIN_NONE;
         4'h0: g = adc_scan_pkg::GAIN_NONE;
      endcase
      return g;
   endfunction

   // highest enabled bit at or below limit; found flag in bit 4
   function automatic logic [4:0] nextBelow(input logic [15:0] list, input logic [4:0] limit);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (list[i] && (5'(i) <= limit)) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // sequencer state
   state_t state_q, state_d;
   logic [3:0] idx_q, idx_d;
   logic [23:0] gapCnt_q, gapCnt_d;
   logic [1:0] pwr_q, pwr_d;
   logic start_q, start_d;

   // data path state
   logic [7:0] mux_q, mux_d;
   logic [1:0] gain_q, gain_d;
   logic [23:0] res_q, res_d;
   logic rdy_q, rdy_d;

   // register file state
   logic [7:0] inSel_q, inSel_d;
   logic [23:0] list_q, list_d;
   logic [23:0] gap_q, gap_d;
   logic scanOn;
   logic [4:0] nextIdx;
   logic scanAct_q, scanAct_d;
   logic [15:0] listMasked;

   // tag field position
   localparam int TAG_POS = adc_scan_pkg::TAG_POS;

   assign scanOn = (list_q[15:0] != 16'h0000);

   for (genvar b = 0; b < 16; b++) begin : g_mask
      assign listMasked[b] = regWdata[b] & LIST_MASK[b];
   end

   always_comb begin
      inSel_d = inSel_q;
      list_d = list_q;
      gap_d = gap_q;
      if (regWrite) begin
         unique case (regAddr)
            adc_scan_pkg::ADDR_INPUT_SEL: inSel_d = regWdata[7:0];
            adc_scan_pkg::ADDR_CHANNEL_LIST: list_d = {regWdata[23:16], listMasked};
            adc_scan_pkg::ADDR_GAP: gap_d = regWdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      gapCnt_d = gapCnt_q;
      pwr_d = pwr_q;
      start_d = 1'b0;
      nextIdx = 5'h00;
      unique case (state_q)
         IDLE: begin
            // power-state writes honoured only outside a cycle
            if (pwrWrite) begin
               pwr_d = pwrWdata;
            end
            if (pwrWrite && pwrWdata == adc_scan_pkg::PWR_CONVERT && scanOn) begin
               // start at most significant enabled bit
               nextIdx = nextBelow(list_q[15:0], 5'h0f);
               idx_d = nextIdx[3:0];
               state_d = CONV;
            end
         end
         CONV: begin
            // one-shot start; converter timing doubles with chopping
            start_d = 1'b1;
            state_d = WAIT_CONV;
         end
         WAIT_CONV: begin
            if (convDone) begin
               nextIdx = nextBelow(list_q[15:0], {1'b0, idx_q} - 5'h01);
               if (idx_q != 4'h0 && nextIdx[4]) begin
                  idx_d = nextIdx[3:0];
                  state_d = CONV;
               end else if (conversion_repeat_select == adc_scan_pkg::REPEAT_CONT) begin
                  gapCnt_d = gap_q;
                  state_d = GAP;
               end else begin
                  // single cycle then standby or shutdown
                  pwr_d = conversion_repeat_select[1] ? adc_scan_pkg::PWR_STANDBY
                                                      : adc_scan_pkg::PWR_SHUTDOWN;
                  state_d = IDLE;
               end
            end
         end
         GAP: begin
            if (gapCnt_q == 24'h000000) begin
               nextIdx = nextBelow(list_q[15:0], 5'h0f);
               idx_d = nextIdx[3:0];
               state_d = CONV;
            end else begin
               gapCnt_d = gapCnt_q - 24'h000001;
            end
         end
      endcase
      // abort when the list is cleared
      if (state_q != IDLE && !scanOn) begin
         state_d = IDLE;
         pwr_d = adc_scan_pkg::PWR_SHUTDOWN;
      end
      scanAct_d = (state_d != IDLE);
   end

   always_comb begin
      mux_d = mux_q;
      gain_d = gain_q;
      unique case (state_q)
         IDLE: begin
            mux_d = inSel_q;
            gain_d = adc_scan_pkg::GAIN_NONE;
         end
         CONV: begin
            mux_d = chanCode(idx_q);
            gain_d = chanGain(idx_q);
         end
         WAIT_CONV, GAP: ;
      endcase
   end

   always_comb begin
      res_d = res_q;
      rdy_d = 1'b0;
      if (state_q == WAIT_CONV && convDone) begin
         res_d = convData;
         rdy_d = 1'b1;
         if (outputFormat == adc_scan_pkg::FORMAT_TAGGED) begin
            res_d[23:TAG_POS] = idx_q;
         end
      end
   end

   // register file
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         inSel_q <= adc_scan_pkg::INPUT_SEL_RESET;
         list_q <= adc_scan_pkg::CHANNEL_LIST_RESET;
         gap_q <= adc_scan_pkg::GAP_RESET;
      end else begin
         inSel_q <= inSel_d;
         list_q <= list_d;
         gap_q <= gap_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= IDLE;
         idx_q <= 4'h0;
         gapCnt_q <= 24'h000000;
         pwr_q <= adc_scan_pkg::PWR_SHUTDOWN;
         start_q <= 1'b0;
         scanAct_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         gapCnt_q <= gapCnt_d;
         pwr_q <= pwr_d;
         start_q <= start_d;
         scanAct_q <= scanAct_d;
      end
   end

   // multiplexer and gain registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mux_q <= adc_scan_pkg::INPUT_SEL_RESET;
         gain_q <= adc_scan_pkg::GAIN_NONE;
      end else begin
         mux_q <= mux_d;
         gain_q <= gain_d;
      end
   end

   // result registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         res_q <= 24'h000000;
         rdy_q <= 1'b0;
      end else begin
         res_q <= res_d;
         rdy_q <= rdy_d;
      end
   end

   // repeat select is only sampled at cycle end, never restarts
   assign convStart = start_q;
   assign muxCode = mux_q;
   assign forcedGain = gain_q;
   assign powerState = pwr_q;
   assign scanActive = scanAct_q;
   assign result_word = res_q;
   assign dataReady = rdy_q;
   assign input_selection = inSel_q;
   assign channel_list_config = list_q;
   assign gapCount = gap_q;
   logic unusedChop;
   assign unusedChop = auto_zero_chop_enable;
endmodule
`default_nettype wire

// >>> design/adc_scan_pkg.sv
package adc_scan_pkg;
   localparam logic [3:0] ADDR_INPUT_SEL = 4'h6;
   localparam logic [3:0] ADDR_CHANNEL_LIST = 4'h7;
   localparam logic [3:0] ADDR_GAP = 4'h8;
   localparam logic [7:0] INPUT_SEL_RESET = 8'h01;
   localparam logic [23:0] CHANNEL_LIST_RESET = 24'h000000;
   localparam logic [23:0] GAP_RESET = 24'h000000;
   localparam logic [1:0] PWR_SHUTDOWN = 2'h0;
   localparam logic [1:0] PWR_STANDBY = 2'h2;
   localparam logic [1:0] PWR_CONVERT = 2'h3;
   localparam logic [1:0] REPEAT_CONT = 2'h3;
   localparam logic [1:0] FORMAT_TAGGED = 2'h3;
   localparam logic [1:0] GAIN_NONE = 2'h0;
   localparam logic [1:0] GAIN_ONE = 2'h1;
   localparam logic [1:0] GAIN_THIRD = 2'h2;
   localparam int TAG_POS = 20;
   localparam int DLY_POS = 20;
   // present list bits per variant: full, two-channel, four-channel
   localparam logic [15:0] LIST_MASK_FULL = 16'hffff;
   localparam logic [15:0] LIST_MASK_TWO = 16'hf103;
   localparam logic [15:0] LIST_MASK_FOUR = 16'hf30f;
endpackage

// >>> verif/adc_scan_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adc_scan_monitor #(
   parameter logic [15:0] LIST_MASK = 16'hffff
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic pwrWrite,
   input wire logic [1:0] pwrWdata,
   input wire logic convDone,
   input wire logic convStart,
   input wire logic [7:0] muxCode,
   input wire logic [1:0] forcedGain,
   input wire logic [1:0] powerState,
   input wire logic scanActive,
   input wire logic dataReady,
   input wire logic [23:0] channel_list_config
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_done_ready: assert property (convDone && scanActive |=> dataReady)
      else $error("result not flagged");
   a_one_shot: assert property (convStart |=> !convStart [*4])
      else $error("conversion restarted");
   a_power_hold: assert property (scanActive |-> powerState == 2'h3)
      else $error("power state dropped");
   a_scan_start: assert property (
      pwrWrite && pwrWdata == 2'h3 && !scanActive && |channel_list_config[15:0]
      |=> scanActive ##1 convStart) else $error("scan did not start");
   a_gain_forced: assert property (
      scanActive && $past(scanActive) |-> forcedGain == (muxCode == 8'h98 ? 2'h2
      : (muxCode == 8'hf8 || muxCode == 8'hde) ? 2'h1 : 2'h0)) else $error("gain wrong");
   a_list_mask: assert property ((channel_list_config[15:0] & ~LIST_MASK) == 16'h0)
      else $error("absent channel stored");
   a_clear_abort: assert property (
      scanActive && channel_list_config[15:0] == 16'h0 |-> ##[0:2] !scanActive)
      else $error("scan not aborted");
   a_cycle_end: assert property ($fell(scanActive) |-> ##[0:1] powerState != 2'h3)
      else $error("power state kept");
   c_third: cover property (scanActive && forcedGain == 2'h2);
   c_ready: cover property (dataReady && scanActive);
   c_end: cover property ($fell(scanActive));
endmodule
bind adc_scan_sequencer adc_scan_monitor #(.LIST_MASK(LIST_MASK)) mon (.clk_sys, .sys_rst,
   .pwrWrite, .pwrWdata, .convDone, .convStart, .muxCode, .forcedGain, .powerState,
   .scanActive, .dataReady, .channel_list_config);
`default_nettype wire

// >>> verif/conv_model.sv
`timescale 1ns/10ps
`default_nettype none
module conv_model #(
   parameter int LAT = 5
) (
   input wire logic clk_sys,
   input wire logic convStart,
   input wire logic auto_zero_chop_enable,
   output logic convDone = 1'b0,
   output logic [23:0] convData = 24'h0
);
   int cnt = 0;
   always @(posedge clk_sys) begin
      convDone <= 1'b0;
      convData <= ~convData;
      // one conversion per start, doubled with chopping
      if (convStart)
         cnt <= auto_zero_chop_enable ? 2 * LAT : LAT;
      else if (cnt > 0)
         cnt <= cnt - 1;
      if (cnt == 1) begin
         convDone <= 1'b1;
         convData <= 24'h05a5a5;
      end
   end
endmodule
`default_nettype wire

// >>> verif/test_adc_scan_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_adc_scan_sequencer;
   logic clk_sys = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, pwrWrite = 1'b0;
   logic auto_zero_chop_enable = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [23:0] regWdata = 24'h0, convData, result_word, channel_list_config, gapCount;
   logic [1:0] conversion_repeat_select = 2'h0, outputFormat = 2'h3, pwrWdata = 2'h0;
   logic [1:0] forcedGain, powerState;
   logic [7:0] muxCode, input_selection;
   logic convDone, convStart, scanActive, dataReady;
   int bad_count = 0, checked = 0;
   adc_scan_sequencer #(.LIST_MASK(adc_scan_pkg::LIST_MASK_FOUR)) dut (.clk_sys, .sys_rst,
      .regWrite, .regAddr, .regWdata, .conversion_repeat_select, .auto_zero_chop_enable,
      .outputFormat, .pwrWrite, .pwrWdata, .convDone, .convData, .convStart, .muxCode,
      .forcedGain, .powerState, .scanActive, .result_word, .dataReady, .input_selection,
      .channel_list_config, .gapCount);
   conv_model model (.clk_sys, .convStart, .auto_zero_chop_enable, .convDone, .convData);
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // register write when isPwr is 0, power-state write otherwise
   task automatic put(input bit isPwr, input logic [3:0] a, input logic [23:0] d);
      regAddr = a;
      regWdata = d;
      pwrWdata = d[1:0];
      regWrite = !isPwr;
      pwrWrite = isPwr;
      @(negedge clk_sys);
      regWrite = 1'b0;
      pwrWrite = 1'b0;
      @(negedge clk_sys);
   endtask
   // waits for dataReady when rdy is 1, for convStart otherwise
   task automatic await(input bit rdy);
      for (int i = 0; i < 300 && !(rdy ? dataReady : convStart); i++)
         @(negedge clk_sys);
      check(rdy ? dataReady : convStart, 24'h1);
      @(negedge clk_sys);
   endtask
   task automatic t_reset();
      check(scanActive, 24'h0);
      check(powerState, 24'h0);
      check(muxCode, 24'h01);
      check(dataReady, 24'h0);
   endtask
   task automatic t_scan();
      put(1'b0, adc_scan_pkg::ADDR_INPUT_SEL, 24'hab);
      check(input_selection, 24'hab);
      put(1'b0, adc_scan_pkg::ADDR_CHANNEL_LIST, 24'hffff);
      check(channel_list_config, 24'hf30f);
      put(1'b1, 4'h0, 24'h3);
      for (int n = 15; n >= 0; n--) begin
         if (adc_scan_pkg::LIST_MASK_FOUR[n]) begin
            if (n == 15)
               for (int i = 0; i < 300 && !convStart; i++) @(negedge clk_sys);
            check(convStart, 24'h1);
            check(muxCode, n > 11 ? 32'h88f898de >> (8 * (n - 12)) & 32'hff
               : n > 7 ? 24'h22 * (n - 8) + 1 : 16 * n + 8);
            check(forcedGain, n == 13 ? 24'h2 : (n == 14 || n == 12) ? 24'h1 : 24'h0);
            @(negedge clk_sys);
            await(1'b1);
            check(result_word[23:20], n);
            check(result_word[19:0], 24'h5a5a5);
         end
      end
      repeat (3) @(negedge clk_sys);
      check(powerState, 24'h0);
   endtask
   task automatic t_repeat();
      put(1'b0, adc_scan_pkg::ADDR_CHANNEL_LIST, 24'h3);
      put(1'b0, adc_scan_pkg::ADDR_GAP, 24'h3);
      conversion_repeat_select = 2'h3;
      auto_zero_chop_enable = 1'b1;
      put(1'b1, 4'h0, 24'h3);
      check(gapCount, 24'h3);
      await(1'b1);
      await(1'b1);
      repeat (4) begin
         check(convStart, 24'h0);
         @(negedge clk_sys);
      end
      check(convStart, 24'h1);
      @(negedge clk_sys);
      await(1'b1);
      // change repeat select just after data-ready
      conversion_repeat_select = 2'h2;
      await(1'b1);
      repeat (2) @(negedge clk_sys);
      check(powerState, 24'h2);
   endtask
   task automatic t_abort();
      conversion_repeat_select = 2'h3;
      put(1'b1, 4'h0, 24'h3);
      await(1'b0);
      put(1'b0, adc_scan_pkg::ADDR_CHANNEL_LIST, 24'h0);
      repeat (3) @(negedge clk_sys);
      check(scanActive, 24'h0);
      check(muxCode, 24'hab);
   endtask
   initial begin
      repeat (6) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset();
      t_scan();
      t_repeat();
      t_abort();
      finish_test();
   end
   initial begin
      #100000;
      bad_count++;
      finish_test();
   end
endmodule
`default_nettype wire
